// ---- pmcc_pkg.sv ----
// package for the power-mode and clock control block
// assumes a single 10 MHz aclk domain and an axi4-lite register slave
// Function
// - bit 7 zero after reset halves oscillator; one passes it undivided.
// - bits 6,3 clear: sleep instruction enters sleep, or system stop with peripheral stop.
// - bit 6 set, bit 3 clear: standby, oscillator stops, 131072-cycle settle on restart.
// - bits 6 and 3 set: quick-recovery standby, only 64 settle cycles.
// - leaving standby by interrupt, bit 3 picks long or 64-cycle delay.
// - bit 5 set: bus request in standby honoured after settle counter expires.
// - in idle with bit 5 set, bus granted 8 cycles later than normal.
// - after bus request drops in idle, clock output gated again, stay idle.
// - reset low, nmi, or enabled low interrupt line exits standby or idle.
// - halt: refetch opcode, halt, status and fetch strobes low, clocks running.
// - during halt, interrupts, grants, refresh, peripherals and dma keep working.
// - normal operation: everything active, halt indicator held high.
// - bits 4,2,1,0 each select 33 percent drive for one pin group.
package pmcc_pkg;
    // ==========================================================
    // register map: offsets are word indices, byte address is four times the index
    localparam logic [7:0] PMCC_CTRL_OFS = 8'h1F;
    localparam logic [7:0] PMCC_STAT_OFS = 8'h20;
    localparam logic [7:0] PMCC_CTRL_RST = 8'h00;
    localparam int PMCC_DIV_BIT = 7;
    localparam int PMCC_STBY_BIT = 6;
    localparam int PMCC_BGNT_BIT = 5;
    localparam int PMCC_LNCLK_BIT = 4;
    localparam int PMCC_QREC_BIT = 3;
    localparam int PMCC_LNPER_BIT = 2;
    localparam int PMCC_LNSTB_BIT = 1;
    localparam int PMCC_LNBUS_BIT = 0;
    // ==========================================================
    // timing counts
    localparam int PMCC_LONG_SETTLE = 131072;
    localparam int PMCC_QUICK_SETTLE = 64;
    localparam int PMCC_IDLE_GRANT_DLY = 8;
    localparam int PMCC_CNT_W = 18;
    // ==========================================================
    // modes and carriers
    typedef enum logic [2:0] {
        PMCC_NORMAL, PMCC_HALT, PMCC_SLEEP, PMCC_SYSSTOP, PMCC_IDLE, PMCC_STANDBY, PMCC_SETTLE
    } pmcc_mode_t;
    typedef struct packed {
        logic clock_out_low_drive;
        logic peripheral_pins_low_drive;
        logic strobe_pins_low_drive;
        logic bus_pins_low_drive;
    } pmcc_drive_t;
    typedef struct packed {
        logic halt_n;
        logic status_strobe_n;
        logic opcode_fetch_strobe_n;
    } pmcc_strobe_t;
endpackage

// ---- pmcc_axil.sv ----
// axi4-lite slave holding the clock and power control register
// assumes one outstanding write and one read; byte lane 0 carries the register
`timescale 1ns/1ns
module pmcc_axil (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [7:0] stat_in,
    output logic [7:0] ctrl
);
    import pmcc_pkg::*;
    logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [7:0] awaddr_q, awaddr_d, ctrl_q, ctrl_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic wl_q, wl_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    // ==========================================================
    // next state
    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wl_d = wl_q;
        ctrl_d = ctrl_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (awvalid && !aw_have_q && !bvalid_q) begin
            aw_have_d = 1'b1;
            awaddr_d = awaddr;
        end
        if (wvalid && !w_have_q && !bvalid_q) begin
            w_have_d = 1'b1;
            wdata_d = wdata;
            wl_d = wstrb[0];
        end
        if (aw_have_q && w_have_q) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = 2'h0;
            if (awaddr_q[7:2] == PMCC_CTRL_OFS[5:0]) begin
                if (wl_q) begin
                    ctrl_d = wdata_q[7:0];
                end
            end else if (awaddr_q[7:2] != PMCC_STAT_OFS[5:0]) begin
                bresp_d = 2'h2;
            end
        end
        if (bvalid_q && bready) begin
            bvalid_d = 1'b0;
        end
        if (arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d = 2'h0;
            rdata_d = 32'h0000_0000;
            if (araddr[7:2] == PMCC_CTRL_OFS[5:0]) begin
                rdata_d = {24'h00_0000, ctrl_q};
            end else if (araddr[7:2] == PMCC_STAT_OFS[5:0]) begin
                rdata_d = {24'h00_0000, stat_in};
            end else begin
                rresp_d = 2'h2;
            end
        end else if (rvalid_q && rready) begin
            rvalid_d = 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wl_q <= 1'b0;
            ctrl_q <= PMCC_CTRL_RST;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'h0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wl_q <= wl_d;
            ctrl_q <= ctrl_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end
    assign awready = !aw_have_q && !bvalid_q;
    assign wready = !w_have_q && !bvalid_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = !rvalid_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign ctrl = ctrl_q;
endmodule // pmcc_axil

// ---- pmcc_settle.sv ----
// oscillator stabilisation counter
// assumes the oscillator tick is a one-cycle enable in the aclk domain
`timescale 1ns/1ns
module pmcc_settle #(
    parameter int LONG_COUNT = pmcc_pkg::PMCC_LONG_SETTLE
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic quick,
    input wire logic osc_tick,
    output logic done
);
    import pmcc_pkg::*;
    logic [PMCC_CNT_W-1:0] cnt_q, cnt_d, term_q, term_d;
    logic run_q, run_d, done_q, done_d;
    always_comb begin
        cnt_d = cnt_q;
        term_d = term_q;
        run_d = run_q;
        done_d = 1'b0;
        if (start) begin
            cnt_d = '0;
            run_d = 1'b1;
            term_d = quick ? PMCC_CNT_W'(PMCC_QUICK_SETTLE - 1) : PMCC_CNT_W'(LONG_COUNT - 1);
        end else if (run_q && osc_tick) begin
            if (cnt_q == term_q) begin
                run_d = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
            term_q <= '0;
            run_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            term_q <= term_d;
            run_q <= run_d;
            done_q <= done_d;
        end
    end
    assign done = done_q;
endmodule // pmcc_settle

// ---- pmcc_top.sv ----
// power-mode and clock control top: mode machine, clock gating, bus grant
// assumes core events (sleep, halt, interrupts, bus request) are synchronous to aclk
`timescale 1ns/1ns
module pmcc_top #(
    parameter int LONG_SETTLE = pmcc_pkg::PMCC_LONG_SETTLE
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic peripheral_stop,
    input wire logic sleep_instruction,
    input wire logic halt_instruction,
    input wire logic halt_release,
    input wire logic nmi,
    input wire logic [2:0] external_interrupt_lines_n,
    input wire logic [2:0] interrupt_enable,
    input wire logic external_bus_request,
    output logic bus_grant,
    output logic system_clock_enable,
    output logic system_clock_out,
    output logic oscillator_run,
    output logic core_clock_enable,
    output pmcc_pkg::pmcc_strobe_t strobes,
    output pmcc_pkg::pmcc_drive_t drive,
    output pmcc_pkg::pmcc_mode_t mode
);
    import pmcc_pkg::*;
    logic [7:0] ctrl;
    logic [7:0] stat;
    logic settle_done;
    logic settle_start;
    pmcc_mode_t mode_q, mode_d;
    logic div_q, div_d, en_q, en_d, clko_q, clko_d, osc_q, osc_d, core_q, core_d;
    logic grant_q, grant_d, settled_q, settled_d;
    logic [3:0] gdly_q, gdly_d;
    pmcc_strobe_t strb_q, strb_d;
    pmcc_drive_t drv_q, drv_d;
    logic wake;

    // ==========================================================
    // registers
    pmcc_axil u_regs (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .stat_in(stat),
        .ctrl(ctrl)
    );
    // status: mode code, grant, oscillator running, settled
    assign stat = {2'h0, settled_q, osc_q, grant_q, mode_q};

    // ==========================================================
    // stabilisation counter
    pmcc_settle #(
        .LONG_COUNT(LONG_SETTLE)
    ) u_settle (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(settle_start),
        .quick(ctrl[PMCC_QREC_BIT]),
        .osc_tick(1'b1),
        .done(settle_done)
    );

    // wake sources; a low aresetn already returns to normal through reset
    assign wake = nmi || ((~external_interrupt_lines_n & interrupt_enable) != 3'h0);
    assign settle_start = (mode_q == PMCC_STANDBY) && wake;

    // ==========================================================
    // mode machine
    always_comb begin
        mode_d = mode_q;
        settled_d = settled_q;
        unique case (mode_q)
            PMCC_NORMAL: begin
                settled_d = 1'b1;
                if (halt_instruction) begin
                    mode_d = PMCC_HALT;
                end else if (sleep_instruction) begin
                    unique case ({ctrl[PMCC_STBY_BIT], ctrl[PMCC_QREC_BIT]})
                        2'b00: mode_d = peripheral_stop ? PMCC_SYSSTOP : PMCC_SLEEP;
                        2'b01: mode_d = peripheral_stop ? PMCC_IDLE : PMCC_SLEEP;
                        default: mode_d = peripheral_stop ? PMCC_STANDBY : PMCC_SLEEP;
                    endcase
                end
            end
            PMCC_HALT: begin
                if (halt_release || wake) begin
                    mode_d = PMCC_NORMAL;
                end
            end
            PMCC_SLEEP, PMCC_SYSSTOP, PMCC_IDLE: begin
                if (wake) begin
                    mode_d = PMCC_NORMAL;
                end
            end
            PMCC_STANDBY: begin
                settled_d = 1'b0;
                if (wake) begin
                    mode_d = PMCC_SETTLE;
                end
            end
            PMCC_SETTLE: begin
                if (settle_done) begin
                    settled_d = 1'b1;
                    mode_d = PMCC_NORMAL;
                end
            end
        endcase
    end

    // ==========================================================
    // clocks, divider, strobes
    always_comb begin
        div_d = ctrl[PMCC_DIV_BIT] ? 1'b1 : ~div_q;
        osc_d = !(mode_q == PMCC_STANDBY);
        core_d = (mode_q == PMCC_NORMAL) || (mode_q == PMCC_HALT) || (mode_q == PMCC_SLEEP);
        en_d = 1'b0;
        if (osc_q && div_d) begin
            en_d = (mode_q == PMCC_NORMAL) || (mode_q == PMCC_HALT) || (mode_q == PMCC_SLEEP) || grant_q;
        end
        clko_d = en_d ? ~clko_q : clko_q;
        strb_d.halt_n = !(mode_q == PMCC_HALT);
        strb_d.status_strobe_n = !(mode_q == PMCC_HALT);
        strb_d.opcode_fetch_strobe_n = !(mode_q == PMCC_HALT);
        drv_d.clock_out_low_drive = ctrl[PMCC_LNCLK_BIT];
        drv_d.peripheral_pins_low_drive = ctrl[PMCC_LNPER_BIT];
        drv_d.strobe_pins_low_drive = ctrl[PMCC_LNSTB_BIT];
        drv_d.bus_pins_low_drive = ctrl[PMCC_LNBUS_BIT];
    end

    // ==========================================================
    // bus grant: idle adds a fixed latency when bit 5 is set (no grant otherwise), standby waits for settle
    always_comb begin
        grant_d = 1'b0;
        gdly_d = 4'h0;
        if (external_bus_request) begin
            unique case (mode_q)
                PMCC_NORMAL, PMCC_HALT, PMCC_SLEEP: grant_d = 1'b1;
                PMCC_IDLE: begin
                    if (ctrl[PMCC_BGNT_BIT]) begin
                        if (gdly_q == 4'(PMCC_IDLE_GRANT_DLY)) begin
                            grant_d = 1'b1;
                            gdly_d = gdly_q;
                        end else begin
                            gdly_d = gdly_q + 4'h1;
                        end
                    end
                end
                PMCC_SETTLE: grant_d = ctrl[PMCC_BGNT_BIT] && settle_done;
                default: grant_d = grant_q && ctrl[PMCC_BGNT_BIT] && settled_q;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= PMCC_NORMAL;
            settled_q <= 1'b1;
            div_q <= 1'b0;
            osc_q <= 1'b1;
            core_q <= 1'b1;
            en_q <= 1'b0;
            clko_q <= 1'b0;
            grant_q <= 1'b0;
            gdly_q <= 4'h0;
            strb_q <= 3'b111;
            drv_q <= 4'h0;
        end else begin
            mode_q <= mode_d;
            settled_q <= settled_d;
            div_q <= div_d;
            osc_q <= osc_d;
            core_q <= core_d;
            en_q <= en_d;
            clko_q <= clko_d;
            grant_q <= grant_d;
            gdly_q <= gdly_d;
            strb_q <= strb_d;
            drv_q <= drv_d;
        end
    end

    assign bus_grant = grant_q;
    assign system_clock_enable = en_q;
    assign system_clock_out = clko_q;
    assign oscillator_run = osc_q;
    assign core_clock_enable = core_q;
    assign strobes = strb_q;
    assign drive = drv_q;
    assign mode = mode_q;
endmodule // pmcc_top

// ---- pmcc_sva.sv ----
// checker for the power-mode and clock control top
// assumes it is bound into pmcc_top and sees only its ports
`timescale 1ns/1ns
module pmcc_sva #(
    parameter int LONG_SETTLE = pmcc_pkg::PMCC_LONG_SETTLE
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic nmi,
    input wire logic external_bus_request,
    input wire logic bus_grant,
    input wire logic system_clock_enable,
    input wire logic system_clock_out,
    input wire logic oscillator_run,
    input wire pmcc_pkg::pmcc_strobe_t strobes,
    input wire pmcc_pkg::pmcc_drive_t drive,
    input wire pmcc_pkg::pmcc_mode_t mode
);
    import pmcc_pkg::*;
    // ==========================
    // settle length, counted here so long waits need no repetition
    logic [17:0] settle_cnt_q;
    logic [17:0] settle_cnt_d;
    always_comb begin
        settle_cnt_d = (mode == PMCC_SETTLE) ? settle_cnt_q + 18'h1 : 18'h0;
    end
    always_ff @(posedge aclk) begin
        settle_cnt_q <= aresetn ? settle_cnt_d : 18'h0;
    end
    // ==========================
    // properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_idle_ask;
        mode == PMCC_IDLE && $rose(external_bus_request);
    endsequence
    sequence s_settle_end;
        $past(mode) == PMCC_SETTLE && mode != PMCC_SETTLE;
    endsequence
    a_reset_state: assert property (disable iff (1'b0) !aresetn |=> mode == PMCC_NORMAL && drive == 4'h0)
        else $error("state not cleared by reset");
    a_halt_strobes: assert property (strobes == (($past(mode) == PMCC_HALT) ? 3'h0 : 3'h7))
        else $error("strobes disagree with halt");
    a_halt_clock: assert property (mode == PMCC_HALT |-> oscillator_run)
        else $error("oscillator stopped in halt");
    a_standby_osc: assert property ($past(mode) == PMCC_STANDBY |-> !oscillator_run)
        else $error("oscillator running in standby");
    a_idle_gate: assert property (mode == PMCC_IDLE && $past(mode) == PMCC_IDLE && !bus_grant
        && !$past(bus_grant) |-> !system_clock_enable)
        else $error("clock gate open in idle");
    a_idle_drop: assert property (mode == PMCC_IDLE && bus_grant && !external_bus_request && !nmi
        |=> !bus_grant && mode == PMCC_IDLE)
        else $error("grant held after request dropped");
    a_idle_late: assert property (s_idle_ask |-> !bus_grant [*8])
        else $error("idle grant too early");
    a_settle_grant: assert property (mode == PMCC_SETTLE |-> !bus_grant)
        else $error("grant before settle expired");
    a_settle_max: assert property (settle_cnt_q <= LONG_SETTLE + 4)
        else $error("settle too long");
    a_settle_min: assert property (s_settle_end |-> settle_cnt_q >= 64)
        else $error("settle too short");
    a_wake_exit: assert property ((mode == PMCC_IDLE || mode == PMCC_STANDBY) && nmi
        |=> mode == PMCC_NORMAL || mode == PMCC_SETTLE)
        else $error("no wake on nmi");
    a_clock_toggle: assert property (system_clock_enable == (system_clock_out != $past(system_clock_out)))
        else $error("clock output toggles without enable");
endmodule // pmcc_sva

// ---- pmcc_far_end.sv ----
// far-side model: external bus master and wake-up sources
// assumes bench commands are levels in the aclk domain
`timescale 1ns/1ns
module pmcc_far_end (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic want_bus,
    input wire logic nmi_cmd,
    input wire logic [2:0] irq_cmd_n,
    output logic external_bus_request,
    output logic nmi,
    output logic [2:0] external_interrupt_lines_n
);
    // ==========================
    // registered so every change lands just after an edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            external_bus_request <= 1'b0;
            nmi <= 1'b0;
            external_interrupt_lines_n <= 3'h7;
        end else begin
            external_bus_request <= want_bus;
            nmi <= nmi_cmd;
            external_interrupt_lines_n <= irq_cmd_n;
        end
    end
endmodule // pmcc_far_end

// ---- power_mode_clock_control_tb_top.sv ----
// bench for the power-mode and clock control block
// assumes one 10 MHz clock; the far-side model drives request and wake lines
`timescale 1ns/1ns
module power_mode_clock_control_tb_top;
    import pmcc_pkg::*;
    localparam int LS = 200;
    localparam logic [7:0] CTRL_A = {PMCC_CTRL_OFS[5:0], 2'b00};
    localparam logic [7:0] STAT_A = {PMCC_STAT_OFS[5:0], 2'b00};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic peripheral_stop = 1'b0, sleep_instruction = 1'b0, halt_instruction = 1'b0, halt_release = 1'b0;
    logic [2:0] interrupt_enable = 3'h0, irq_cmd_n = 3'h7, external_interrupt_lines_n;
    logic want_bus = 1'b0, nmi_cmd = 1'b0, nmi, external_bus_request, bus_grant;
    logic system_clock_enable, system_clock_out, oscillator_run, core_clock_enable;
    pmcc_strobe_t strobes;
    pmcc_drive_t drive;
    pmcc_mode_t mode;
    pmcc_mode_t em[5] = '{PMCC_SLEEP, PMCC_SYSSTOP, PMCC_IDLE, PMCC_STANDBY, PMCC_STANDBY};
    logic [7:0] cfg[5] = '{8'h00, 8'h00, 8'h28, 8'h68, 8'h60};
    logic [31:0] exp_q[$], obs_q[$];
    logic [7:0] lfsr = 8'h4E;
    int errors = 0, n_tests = 0;
    int n, n_norm, e;

    pmcc_top #(.LONG_SETTLE(LS)) dut (.*);
    pmcc_far_end far (.*);

    always #50 aclk = ~aclk;

    // ==========================
    // result watcher
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) obs_q.push_back(32'(s_axi_bresp));
        if (s_axi_rvalid && s_axi_rready) begin
            obs_q.push_back(s_axi_rdata);
            obs_q.push_back(32'(s_axi_rresp));
        end
        while (exp_q.size() > 0 && obs_q.size() > 0) begin
            n_tests++;
            if (obs_q[0] !== exp_q[0]) begin
                errors++;
                $display("unexpected at %0t: got %h expected %h", $time, obs_q[0], exp_q[0]);
            end
            void'(obs_q.pop_front());
            void'(exp_q.pop_front());
        end
    end

    // ==========================
    // tasks
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic finish_test();
        errors += exp_q.size();
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic tmo();
        errors++;
        finish_test();
    endtask
    task automatic look(input logic [31:0] v, input logic [31:0] x);
        obs_q.push_back(v);
        exp_q.push_back(x);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic [2:0] p;
        p = 3'h7;
        exp_q.push_back(32'(r));
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (int k = 0; p != 3'h0; k++) begin
            @(posedge aclk);
            if (p[2] && s_axi_awready) begin p[2] = 1'b0; s_axi_awvalid <= 1'b0; end
            if (p[1] && s_axi_wready) begin p[1] = 1'b0; s_axi_wvalid <= 1'b0; end
            if (p[0] && s_axi_bvalid) begin p[0] = 1'b0; s_axi_bready <= 1'b0; end
            if (k > 40) tmo();
        end
        @(posedge aclk);
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic [1:0] p;
        p = 2'h3;
        exp_q.push_back(d);
        exp_q.push_back(32'(r));
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (int k = 0; p != 2'h0; k++) begin
            @(posedge aclk);
            if (p[1] && s_axi_arready) begin p[1] = 1'b0; s_axi_arvalid <= 1'b0; end
            if (p[0] && s_axi_rvalid) begin p[0] = 1'b0; s_axi_rready <= 1'b0; end
            if (k > 40) tmo();
        end
        @(posedge aclk);
    endtask
    task automatic wait_mode(input pmcc_mode_t m, input int lim, output int c);
        for (c = 0; mode !== m; c++) begin
            @(posedge aclk);
            if (c > lim) tmo();
        end
    endtask
    task automatic bus_lat(output int c);
        want_bus <= 1'b1;
        for (c = 0; bus_grant !== 1'b1; c++) begin
            @(posedge aclk);
            if (c > 40) tmo();
        end
    endtask
    task automatic cnt_en(output int c);
        c = 0;
        repeat (2) @(posedge aclk);
        repeat (20) begin
            @(posedge aclk);
            c += int'(system_clock_enable);
        end
    endtask
    task automatic pulse(input int w);
        sleep_instruction <= (w == 0);
        halt_instruction <= (w == 1);
        halt_release <= (w == 2);
        @(posedge aclk);
        {sleep_instruction, halt_instruction, halt_release} <= 3'h0;
        repeat (2) @(posedge aclk);
    endtask

    // ==========================
    // main sequence
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        look(32'({mode, strobes}), 32'({PMCC_NORMAL, 3'h7}));
        axi_rd(CTRL_A, 32'h0, 2'h0);
        axi_rd(8'h40, 32'h0, 2'h2);
        axi_wr(STAT_A, 32'hFF, 2'h0);
        cnt_en(n);
        look(32'(n), 32'h0A);
        axi_wr(CTRL_A, 32'h80, 2'h0);
        cnt_en(n);
        look(32'(n), 32'h14);
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            axi_wr(CTRL_A, {24'h0, lfsr & 8'h17}, 2'h0);
            @(posedge aclk);
            look(32'(drive), 32'({lfsr[4], lfsr[2:0]}));
            axi_rd(CTRL_A, {24'h0, lfsr & 8'h17}, 2'h0);
        end
        for (int i = 0; i < 5; i++) begin
            axi_wr(CTRL_A, 32'(cfg[i]), 2'h0);
            peripheral_stop <= (i != 0);
            if (i == 2) begin
                bus_lat(n_norm);
                want_bus <= 1'b0;
                repeat (3) @(posedge aclk);
            end
            pulse(0);
            look(32'({mode, oscillator_run, core_clock_enable}),
                32'({em[i], em[i] != PMCC_STANDBY, em[i] == PMCC_SLEEP}));
            if (i == 2) begin
                bus_lat(n);
                look(32'(n), 32'(n_norm + 8));
                want_bus <= 1'b0;
                repeat (4) @(posedge aclk);
                look(32'({mode, bus_grant, system_clock_enable}), 32'({PMCC_IDLE, 2'h0}));
            end
            if (i > 2) want_bus <= 1'b1;
            irq_cmd_n <= 3'h6;
            repeat (3) @(posedge aclk);
            look(32'(mode), 32'(em[i]));
            if (i[0]) nmi_cmd <= 1'b1;
            else interrupt_enable <= 3'h1;
            @(posedge aclk);
            nmi_cmd <= 1'b0;
            e = cfg[i][3] ? 64 : LS;
            if (em[i] == PMCC_STANDBY) begin
                wait_mode(PMCC_SETTLE, 5, n);
                wait_mode(PMCC_NORMAL, LS + 80, n);
                look(32'({n >= e && n <= e + 4, bus_grant}), 32'h3);
            end else begin
                wait_mode(PMCC_NORMAL, 5, n);
            end
            want_bus <= 1'b0;
            irq_cmd_n <= 3'h7;
            interrupt_enable <= 3'h0;
            repeat (3) @(posedge aclk);
        end
        axi_wr(CTRL_A, 32'h28, 2'h0);
        pulse(1);
        look(32'({mode, strobes, oscillator_run}), 32'({PMCC_HALT, 3'h0, 1'b1}));
        bus_lat(n);
        look(32'(n), 32'(n_norm));
        want_bus <= 1'b0;
        repeat (3) @(posedge aclk);
        pulse(2);
        look(32'({mode, strobes}), 32'({PMCC_NORMAL, 3'h7}));
        pulse(1);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        look(32'({mode, strobes, drive}), 32'({PMCC_NORMAL, 3'h7, 4'h0}));
        repeat (3) @(posedge aclk);
        finish_test();
    end
endmodule // power_mode_clock_control_tb_top

bind pmcc_top pmcc_sva #(.LONG_SETTLE(LONG_SETTLE)) u_sva (
    .aclk(aclk), .aresetn(aresetn), .nmi(nmi), .external_bus_request(external_bus_request),
    .bus_grant(bus_grant), .system_clock_enable(system_clock_enable), .oscillator_run(oscillator_run),
    .strobes(strobes), .drive(drive), .mode(mode), .system_clock_out(system_clock_out)
);
